// *** hw/eipl_cfg.svh ***
// constants for the external interrupt pin logic
`ifndef EIPL_CFG_SVH
`define EIPL_CFG_SVH

// ************************************************************
// register addresses and reset values
// ************************************************************
`define EIPL_CFG_ADDR 8'hE4
`define EIPL_CFG_RESET 8'h01
`define EIPL_TIMER_CONTROL_REG_ADDR 8'h88
`define EIPL_TIMER_CONTROL_REG_RESET 8'h00
`define EIPL_RDATA_IDLE 8'h00

// ************************************************************
// field positions, widths and counts
// ************************************************************
`define EIPL_NUM_CHAN 2
`define EIPL_NUM_PINS 8
`define EIPL_CFG_HALF_W 4
`define EIPL_TIMER_CONTROL_REG_EDGE_BIT0 0
`define EIPL_TIMER_CONTROL_REG_PEND_BIT0 1
`define EIPL_TIMER_CONTROL_REG_CHAN_STRIDE 2
`define EIPL_SYNC_STAGES 2

`endif

// *** hw/eipl_chan.sv ***
// one external interrupt channel: polarity, edge or level, pending flag
module eipl_chan (
  input logic clk,
  input logic rst_n,
  eipl_chan_if.chan ch
);

  logic active;
  logic active_q;
  logic rise;
  logic pend_q;

  // ************************************************************
  // active level and edge detect
  // ************************************************************
  assign active = (ch.pin_level == ch.polarity);
  assign rise = active & ~active_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      active_q <= 1'b0;
    end else begin
      active_q <= active;
    end
  end

  // ************************************************************
  // pending flag
  // ************************************************************
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pend_q <= 1'b0;
    end else if (!ch.edge_mode) begin
      pend_q <= active;
    end else if (rise) begin
      pend_q <= 1'b1;
    end else if (ch.vector_ack) begin
      pend_q <= 1'b0;
    end else if (ch.sw_we) begin
      pend_q <= ch.sw_value;
    end
  end

  assign ch.pending = pend_q;

  // ************************************************************
  // checks
  // ************************************************************
  property p_level_follow;
    @(posedge clk) disable iff (!rst_n)
      !ch.edge_mode |=> (pend_q == $past(active));
  endproperty
  a_level_follow: assert property (p_level_follow) else $error("level flag not following");

  sequence s_inactive_then_active;
    (ch.edge_mode && !active) ##1 (ch.edge_mode && active);
  endsequence

  property p_edge_set;
    @(posedge clk) disable iff (!rst_n)
      s_inactive_then_active |=> pend_q;
  endproperty
  a_edge_set: assert property (p_edge_set) else $error("edge did not set flag");

  property p_edge_ack_clear;
    @(posedge clk) disable iff (!rst_n)
      (ch.edge_mode && ch.vector_ack && !rise) |=> !pend_q;
  endproperty
  a_edge_ack_clear: assert property (p_edge_ack_clear) else $error("vector did not clear");

  property p_edge_latch;
    @(posedge clk) disable iff (!rst_n)
      (ch.edge_mode && pend_q && !ch.vector_ack && !ch.sw_we) |=> pend_q;
  endproperty
  a_edge_latch: assert property (p_edge_latch) else $error("edge flag lost");

  property p_polarity;
    @(posedge clk) disable iff (!rst_n)
      (!ch.edge_mode && ch.polarity) ##1 !ch.edge_mode |-> pend_q == $past(ch.pin_level);
  endproperty
  a_polarity: assert property (p_polarity) else $error("active high not honoured");

endmodule

// *** hw/eipl_chan_if.sv ***
// carrier between the top and one interrupt channel
interface eipl_chan_if;
  logic pin_level;
  logic polarity;
  logic edge_mode;
  logic vector_ack;
  logic sw_we;
  logic sw_value;
  logic pending;

  modport ctl (
    output pin_level,
    output polarity,
    output edge_mode,
    output vector_ack,
    output sw_we,
    output sw_value,
    input pending
  );

  modport chan (
    input pin_level,
    input polarity,
    input edge_mode,
    input vector_ack,
    input sw_we,
    input sw_value,
    output pending
  );
endinterface

// *** hw/eipl_pkg.sv ***
// types for the external interrupt pin logic
package eipl_pkg;

  typedef logic [2:0] eipl_pin_sel_t;

  // one channel's half of the pin configuration byte
  typedef struct packed {
    logic polarity;
    eipl_pin_sel_t pin_select;
  } eipl_cfg_half_t;

  typedef logic [7:0] eipl_byte_t;

endpackage

// *** hw/eipl_top.sv ***
// external interrupt pin logic: pin sync, selection, config and flags
// Notes on behaviour
// - polarity bit 0 means the input is active low, 1 means active high.
// - edge bit 1 makes a channel edge sensitive, 0 level, independent of polarity.
// - a 3-bit select per channel picks port 0 pin 0 to 7 in binary order.
// - pins are only sampled, never driven or disturbed, whatever the crossbar does.
// - pending flags sit at bit 1 (channel zero) and bit 3 (channel one) of timer control.
// - in edge mode the pending flag clears when the core vectors to the routine.
// - in level mode the pending flag follows the active level with no latching.
`include "eipl_cfg.svh"

module eipl_top (
  input logic REF_CLK,
  input logic RSTN,
  input logic [7:0] P0_IN,
  input logic [7:0] SFR_ADDR,
  input logic SFR_WE,
  input logic [7:0] SFR_WDATA,
  input logic SFR_RE,
  output logic [7:0] SFR_RDATA,
  input logic IRQ_ZERO_ACK,
  input logic IRQ_ONE_ACK,
  output logic IRQ_ZERO_PENDING,
  output logic IRQ_ONE_PENDING
);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  logic [7:0] pin_meta_q;
  logic [7:0] pin_sync_q;

  generate
    for (genvar p = 0; p < `EIPL_NUM_PINS; p++) begin : g_pin
      always_ff @(posedge REF_CLK) begin
        if (!RSTN) begin
          pin_meta_q[p] <= 1'b0;
          pin_sync_q[p] <= 1'b0;
        end else begin
          pin_meta_q[p] <= P0_IN[p];
          pin_sync_q[p] <= pin_meta_q[p];
        end
      end
    end
  endgenerate

  // ************************************************************
  // registers
  // ************************************************************
  eipl_pkg::eipl_byte_t cfg_q;
  logic [1:0] edge_mode_q;
  logic [1:0] pending;
  logic [1:0] ack;
  logic cfg_hit;
  logic timer_control_reg_hit;
  logic timer_control_reg_we;
  eipl_pkg::eipl_byte_t rdata_d;
  eipl_pkg::eipl_byte_t rdata_q;

  assign cfg_hit = (SFR_ADDR == `EIPL_CFG_ADDR);
  assign timer_control_reg_hit = (SFR_ADDR == `EIPL_TIMER_CONTROL_REG_ADDR);
  assign timer_control_reg_we = SFR_WE && timer_control_reg_hit;
  assign ack = {IRQ_ONE_ACK, IRQ_ZERO_ACK};

  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      cfg_q <= `EIPL_CFG_RESET;
    end else if (SFR_WE && cfg_hit) begin
      cfg_q <= SFR_WDATA;
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      edge_mode_q <= 2'h0;
    end else if (timer_control_reg_we) begin
      edge_mode_q[0] <= SFR_WDATA[`EIPL_TIMER_CONTROL_REG_EDGE_BIT0];
      edge_mode_q[1] <= SFR_WDATA[`EIPL_TIMER_CONTROL_REG_EDGE_BIT0 + `EIPL_TIMER_CONTROL_REG_CHAN_STRIDE];
    end
  end

  // ************************************************************
  // channels
  // ************************************************************
  generate
    for (genvar c = 0; c < `EIPL_NUM_CHAN; c++) begin : g_chan
      eipl_chan_if ch_if ();
      eipl_pkg::eipl_cfg_half_t half;
      localparam int PB = `EIPL_TIMER_CONTROL_REG_PEND_BIT0 + c * `EIPL_TIMER_CONTROL_REG_CHAN_STRIDE;

      assign half = cfg_q[c*`EIPL_CFG_HALF_W +: `EIPL_CFG_HALF_W];
      assign ch_if.pin_level = pin_sync_q[half.pin_select];
      assign ch_if.polarity = half.polarity;
      assign ch_if.edge_mode = edge_mode_q[c];
      assign ch_if.vector_ack = ack[c];
      assign ch_if.sw_we = timer_control_reg_we;
      assign ch_if.sw_value = SFR_WDATA[PB];
      assign pending[c] = ch_if.pending;

      eipl_chan u_chan (
        .clk(REF_CLK),
        .rst_n(RSTN),
        .ch(ch_if.chan)
      );

      property p_pin_select;
        @(posedge REF_CLK) disable iff (!RSTN)
          ch_if.pin_level == pin_sync_q[cfg_q[c*`EIPL_CFG_HALF_W +: 3]];
      endproperty
      a_pin_select: assert property (p_pin_select) else $error("wrong pin selected");
    end
  endgenerate

  assign IRQ_ZERO_PENDING = pending[0];
  assign IRQ_ONE_PENDING = pending[1];

  // ************************************************************
  // read path
  // ************************************************************
  always_comb begin
    rdata_d = `EIPL_RDATA_IDLE;
    if (cfg_hit) begin
      rdata_d = cfg_q;
    end else if (timer_control_reg_hit) begin
      rdata_d[`EIPL_TIMER_CONTROL_REG_EDGE_BIT0] = edge_mode_q[0];
      rdata_d[`EIPL_TIMER_CONTROL_REG_PEND_BIT0] = pending[0];
      rdata_d[`EIPL_TIMER_CONTROL_REG_EDGE_BIT0 + `EIPL_TIMER_CONTROL_REG_CHAN_STRIDE] = edge_mode_q[1];
      rdata_d[`EIPL_TIMER_CONTROL_REG_PEND_BIT0 + `EIPL_TIMER_CONTROL_REG_CHAN_STRIDE] = pending[1];
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RSTN) begin
      rdata_q <= `EIPL_RDATA_IDLE;
    end else if (SFR_RE) begin
      rdata_q <= rdata_d;
    end
  end

  assign SFR_RDATA = rdata_q;

  // ************************************************************
  // checks
  // ************************************************************
  property p_pin_sample;
    @(posedge REF_CLK) disable iff (!RSTN)
      RSTN && $past(RSTN) && $past(RSTN, 2) |-> pin_sync_q == $past(P0_IN, 2);
  endproperty
  a_pin_sample: assert property (p_pin_sample) else $error("pin sample path broken");

  sequence s_timer_control_reg_read;
    SFR_RE && timer_control_reg_hit;
  endsequence

  property p_pend_readback;
    @(posedge REF_CLK) disable iff (!RSTN)
      s_timer_control_reg_read |=> SFR_RDATA[3:0] == {$past(pending[1]), $past(edge_mode_q[1]),
                                         $past(pending[0]), $past(edge_mode_q[0])};
  endproperty
  a_pend_readback: assert property (p_pend_readback) else $error("flag readback wrong");

  property p_edge_write;
    @(posedge REF_CLK) disable iff (!RSTN)
      timer_control_reg_we |=> edge_mode_q == {$past(SFR_WDATA[2]), $past(SFR_WDATA[0])};
  endproperty
  a_edge_write: assert property (p_edge_write) else $error("edge bits not written");

  property p_level_out;
    @(posedge REF_CLK) disable iff (!RSTN)
      (!edge_mode_q[0] && !IRQ_ZERO_ACK) [*2] |-> IRQ_ZERO_PENDING ==
        ($past(g_chan[0].ch_if.pin_level) == $past(cfg_q[3]));
  endproperty
  a_level_out: assert property (p_level_out) else $error("level output wrong");

  property p_level_out_one;
    @(posedge REF_CLK) disable iff (!RSTN)
      (!edge_mode_q[1] && !IRQ_ONE_ACK) [*2] |-> IRQ_ONE_PENDING ==
        ($past(g_chan[1].ch_if.pin_level) == $past(cfg_q[7]));
  endproperty
  a_level_out_one: assert property (p_level_out_one) else $error("level output one wrong");

  property p_cfg_write;
    @(posedge REF_CLK) disable iff (!RSTN)
      SFR_WE && cfg_hit |=> cfg_q == $past(SFR_WDATA);
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("config write lost");

  property p_cfg_hold;
    @(posedge REF_CLK) disable iff (!RSTN)
      !(SFR_WE && cfg_hit) |=> cfg_q == $past(cfg_q);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("config changed unasked");

  property p_edge_hold;
    @(posedge REF_CLK) disable iff (!RSTN)
      !timer_control_reg_we |=> edge_mode_q == $past(edge_mode_q);
  endproperty
  a_edge_hold: assert property (p_edge_hold) else $error("edge bits changed unasked");

  property p_cfg_read;
    @(posedge REF_CLK) disable iff (!RSTN)
      SFR_RE && cfg_hit |=> SFR_RDATA == $past(cfg_q);
  endproperty
  a_cfg_read: assert property (p_cfg_read) else $error("config readback wrong");

  property p_unmapped_read;
    @(posedge REF_CLK) disable iff (!RSTN)
      SFR_RE && !cfg_hit && !timer_control_reg_hit |=> SFR_RDATA == `EIPL_RDATA_IDLE;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");

  property p_timer_control_reg_upper;
    @(posedge REF_CLK) disable iff (!RSTN)
      s_timer_control_reg_read |=> SFR_RDATA[7:4] == 4'h0;
  endproperty
  a_timer_control_reg_upper: assert property (p_timer_control_reg_upper) else $error("timer control upper bits set");

  property p_rdata_hold;
    @(posedge REF_CLK) disable iff (!RSTN)
      !SFR_RE |=> SFR_RDATA == $past(SFR_RDATA);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed unasked");

endmodule

// *** verification/eipl_src_model.sv ***
// external interrupt source model driving port 0
module eipl_src_model (
  input wire logic clk,
  input wire logic [2:0] sel,
  input wire logic lvl,
  input wire logic [7:0] noise,
  output logic [7:0] p0
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // selected pin held at the asked level, others follow the noise input
  // ************************************************************
  // the source is the only driver of the port pins
  always @(negedge clk) begin
    p0 <= (noise & ~(8'h01 << sel)) | (8'(lvl) << sel);
  end
endmodule

// *** verification/external_interrupt_pin_logic_bench.sv ***
// self-checking bench for the external interrupt pin logic
`include "eipl_cfg.svh"

module external_interrupt_pin_logic_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic REF_CLK = 1'b0;
  logic RSTN = 1'b0;
  logic SFR_WE = 1'b0;
  logic SFR_RE = 1'b0;
  logic [7:0] SFR_ADDR = 8'h00;
  logic [7:0] SFR_WDATA = 8'h00;
  logic [7:0] noise = 8'h00;
  logic ack0 = 1'b0;
  logic ack1 = 1'b0;
  logic lvl = 1'b0;
  logic chs = 1'b0;
  logic [2:0] sel = 3'h0;
  logic [7:0] P0_IN, SFR_RDATA, d, msk;
  logic pend0, pend1, pn, pol;
  int fails = 0;
  int tests_run = 0;
  int cycles = 0;
  assign pn = chs ? pend1 : pend0;
  always #5 REF_CLK = ~REF_CLK;
  eipl_top i_dut (.REF_CLK(REF_CLK), .RSTN(RSTN), .P0_IN(P0_IN), .SFR_ADDR(SFR_ADDR),
    .SFR_WE(SFR_WE), .SFR_WDATA(SFR_WDATA), .SFR_RE(SFR_RE), .SFR_RDATA(SFR_RDATA),
    .IRQ_ZERO_ACK(ack0), .IRQ_ONE_ACK(ack1), .IRQ_ZERO_PENDING(pend0),
    .IRQ_ONE_PENDING(pend1));
  eipl_src_model i_src (.clk(REF_CLK), .sel(sel), .lvl(lvl), .noise(noise), .p0(P0_IN));
  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(int n);
    repeat (n) begin
      @(negedge REF_CLK);
      noise = 8'($urandom);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] v);
    @(negedge REF_CLK);
    SFR_ADDR = a;
    SFR_WDATA = v;
    SFR_WE = 1'b1;
    @(negedge REF_CLK);
    SFR_WE = 1'b0;
  endtask
  task automatic rd(logic [7:0] a, output logic [7:0] v);
    @(negedge REF_CLK);
    SFR_ADDR = a;
    SFR_RE = 1'b1;
    @(negedge REF_CLK);
    SFR_RE = 1'b0;
    v = SFR_RDATA;
  endtask
  task automatic ackp();
    @(negedge REF_CLK);
    ack0 = ~chs;
    ack1 = chs;
    @(negedge REF_CLK);
    ack0 = 1'b0;
    ack1 = 1'b0;
  endtask
  always @(posedge REF_CLK) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      stop_test();
    end
  end
  // ************************************************************
  // behavioural reference
  // ************************************************************
  logic [7:0] m_pins[$];
  int m_cfg = 1;
  int m_edge[2] = '{0, 0};
  int m_pend[2] = '{0, 0};
  int m_prev[2] = '{0, 0};
  int m_act = 0;
  always @(posedge REF_CLK) begin
    if (!RSTN) begin
      m_pins = '{8'h00, 8'h00};
      m_cfg = `EIPL_CFG_RESET;
      m_edge = '{0, 0};
      m_pend = '{0, 0};
      m_prev = '{0, 0};
    end else begin
      for (int c = 0; c < 2; c++) begin
        m_act = (m_pins[0][(m_cfg >> (4 * c)) & 7] == ((m_cfg >> (4 * c + 3)) & 1));
        if (m_edge[c] == 0) begin
          m_pend[c] = m_act;
        end else if (m_act == 1 && m_prev[c] == 0) begin
          m_pend[c] = 1;
        end else if ((c == 0 && ack0) || (c == 1 && ack1)) begin
          m_pend[c] = 0;
        end else if (SFR_WE && SFR_ADDR == `EIPL_TIMER_CONTROL_REG_ADDR) begin
          m_pend[c] = SFR_WDATA[1 + 2 * c];
        end
        m_prev[c] = m_act;
      end
      if (SFR_WE && SFR_ADDR == `EIPL_CFG_ADDR) begin
        m_cfg = SFR_WDATA;
      end
      if (SFR_WE && SFR_ADDR == `EIPL_TIMER_CONTROL_REG_ADDR) begin
        m_edge[0] = SFR_WDATA[0];
        m_edge[1] = SFR_WDATA[2];
      end
      void'(m_pins.pop_front());
      m_pins.push_back(P0_IN);
    end
  end
  always @(negedge REF_CLK) begin
    if (RSTN) begin
      check("pending zero", {7'h00, pend0}, 8'(m_pend[0]));
      check("pending one", {7'h00, pend1}, 8'(m_pend[1]));
    end
  end
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    noise = 8'($urandom(88673));
    repeat (10) @(negedge REF_CLK);
    RSTN = 1'b1;
    rd(`EIPL_CFG_ADDR, d);
    check("config reset", d, 8'h01);
    rd(`EIPL_TIMER_CONTROL_REG_ADDR, d);
    check("timer_control_reg reset", d, {4'h0, ~P0_IN[0], 1'b0, ~P0_IN[1], 1'b0});
    wr(8'h55, 8'hFF);
    rd(8'h55, d);
    check("unmapped", d, 8'h00);
    rd(`EIPL_CFG_ADDR, d);
    check("config kept", d, 8'h01);
    for (int c = 0; c < 2; c++) begin
      for (int p = 0; p < 2; p++) begin
        chs = c[0];
        pol = p[0];
        sel = 3'($urandom);
        lvl = ~pol;
        msk = 8'hF0 | (8'h03 << (2 * c));
        wr(`EIPL_TIMER_CONTROL_REG_ADDR, 8'h00);
        wr(`EIPL_CFG_ADDR, 8'({pol, sel}) << (4 * c));
        tick(5);
        check("level idle", {7'h00, pn}, 8'(lvl == pol));
        lvl = pol;
        tick(5);
        check("level active", {7'h00, pn}, 8'(lvl == pol));
        ackp();
        check("level ack", {7'h00, pn}, 8'h01);
        rd(`EIPL_TIMER_CONTROL_REG_ADDR, d);
        check("timer_control_reg level", d & msk, 8'h02 << (2 * c));
        lvl = ~pol;
        tick(5);
        check("level drop", {7'h00, pn}, 8'h00);
        wr(`EIPL_TIMER_CONTROL_REG_ADDR, 8'h01 << (2 * c));
        tick(3);
        check("edge idle", {7'h00, pn}, 8'h00);
        lvl = pol;
        tick(5);
        check("edge set", {7'h00, pn}, 8'h01);
        lvl = ~pol;
        tick(5);
        check("edge held", {7'h00, pn}, 8'h01);
        rd(`EIPL_TIMER_CONTROL_REG_ADDR, d);
        check("timer_control_reg edge", d & msk, 8'h03 << (2 * c));
        ackp();
        check("edge ack", {7'h00, pn}, 8'h00);
      end
    end
    lvl = pol;
    tick(5);
    check("edge before reset", {7'h00, pn}, 8'h01);
    RSTN = 1'b0;
    tick(3);
    RSTN = 1'b1;
    check("reset pending", {7'h00, pn}, 8'h00);
    rd(`EIPL_CFG_ADDR, d);
    check("config after reset", d, `EIPL_CFG_RESET);
    rd(`EIPL_TIMER_CONTROL_REG_ADDR, d);
    check("edge after reset", d & 8'hF5, 8'h00);
    stop_test();
  end
endmodule
